// file: core/vector_access_controller.sv
// Test vector bus master that turns external vectors into system bus transfers.
//
// What this block does
// - Drivers off after read burst, one cycle.
// - Last of successive address vectors is control.
// - Control vector taken only when bit0 high.
// - Control when prior address, next not address.
// - Only incrementing undefined-length bursts issued.
// - Eight-bit incrementer wraps, issuing nonsequential.
// - Two address cycles after read keep address.
// - One address cycle then both low exits.
// - All flops rising edge, async low reset.
// - Grant tracker moves only when ready high.
// - Reset: idle, no request, acknowledge low.
// - Acknowledge low holds state except idle exit and both-low exit.
// - Idle to start uses synchronised request A.
// - Start leaves only on address or exit vector.
// - Write vector enters write state, starts transfer.
// - First read cycle tristated, later cycles driven.
// - Final read then turnaround, bus tristated.
// - Both requests low returns to idle from any state except read.
// - Previous address kept for regenerated transfer.
// - First transfer uses address, then increments.
// - Control vector bit layout as defined.
// - Request pins name the next vector.
// - Incrementer disabled after reset.
// - Stalled transfer drops acknowledge; tester repeats.
`timescale 1ns/1ps
`default_nettype none
module vector_access_controller
	import vector_access_pkg::*;
(
	// Clock and reset
	input  wire logic             core_clk_i,
	input  wire logic             nrst_i,
	// Tester side
	input  wire logic             vector_request_a_i,
	input  wire logic             vector_request_b_i,
	input  wire logic [BUS_W-1:0] shared_vector_bus_i,
	output logic      [BUS_W-1:0] shared_vector_bus_o,
	output logic                  shared_vector_bus_oe_o,
	output logic                  vector_acknowledge_o,
	input  wire logic             clock_switch_done_i,
	// System bus master
	input  wire logic             hgrant_i,
	input  wire logic             hready_i,
	input  wire logic [1:0]       hresp_i,
	input  wire logic [BUS_W-1:0] hrdata_i,
	output logic                  hbusreq_o,
	output logic                  hlock_o,
	output logic      [1:0]       htrans_o,
	output logic      [BUS_W-1:0] haddr_o,
	output logic                  hwrite_o,
	output logic      [2:0]       hsize_o,
	output logic      [2:0]       hburst_o,
	output logic      [3:0]       hprot_o,
	output logic      [BUS_W-1:0] hwdata_o
);

	typedef struct packed {
		vec_state_t       vst;
		grant_state_t     gst;
		logic             req_a_s1;
		logic             req_a_s2;
		logic             prev_was_addr;
		logic             first_xfer;
		logic             first_rd;
		logic             last_wr;
		logic [BUS_W-1:0] held_addr;
		logic [BUS_W-1:0] prev_addr;
		logic             inc_en;
		logic [1:0]       size;
		logic             lock;
		logic [3:0]       prot;
		logic [1:0]       htrans;
		logic [BUS_W-1:0] haddr;
		logic             hwrite;
		logic [BUS_W-1:0] hwdata;
		logic             dphase_act;
		logic             dphase_rd;
		logic             regen;
		logic             ack;
		logic             busreq;
		logic             oe;
	} ctl_t;

	ctl_t q;
	ctl_t n;

	logic             adv;
	logic             issue;
	logic             is_wr;
	logic             seq_ok;
	logic             wrap;
	logic             rsp_fail;
	logic [1:0]       req;
	logic [BUS_W-1:0] xfer_addr;
	vec_state_t       nxt;
	logic             buf_in_valid;
	logic             buf_in_ready;
	logic             buf_out_ready;
	logic             latch_now;
	logic [BUS_W-1:0] base_addr;
	logic             base_first;
	logic             rd_pending;

	// ----------------------------------------------------------------
	// Address incrementer
	// ----------------------------------------------------------------
	// Advances the eight-bit slice picked by the size; the top bit reports a wrap.
	function automatic logic [BUS_W:0] inc_addr(input logic [BUS_W-1:0] a,
		input logic [1:0] sz);
		logic [BUS_W-1:0] r;
		logic [INC_W:0]   s;
		r = a;
		s = '0;
		if (sz == SZ_WORD)
		begin
			s = {1'b0, a[INC_W+1:2]} + 9'h1;
			r[INC_W+1:2] = s[INC_W-1:0];
		end
		else if (sz == SZ_HALF)
		begin
			s = {1'b0, a[INC_W:1]} + 9'h1;
			r[INC_W:1] = s[INC_W-1:0];
		end
		else
		begin
			s = {1'b0, a[INC_W-1:0]} + 9'h1;
			r[INC_W-1:0] = s[INC_W-1:0];
		end
		return {s[INC_W], r};
	endfunction

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb
	begin
		n = q;
		req = {vector_request_a_i, vector_request_b_i};
		n.req_a_s1 = vector_request_a_i;
		n.req_a_s2 = q.req_a_s1;
		if (hready_i)
			n.gst = hgrant_i ? GS_OWNED : GS_OTHER;
		adv = q.ack & hready_i & hgrant_i;
		nxt = q.vst;
		case (q.vst)
			VS_IDLE:
				if (q.req_a_s2 && clock_switch_done_i)
					nxt = VS_START;
			VS_START:
				if (adv && req == VEC_ADDR)
					nxt = VS_ADDR;
				else if (adv && req == VEC_EXIT)
					nxt = VS_IDLE;
			VS_ADDR, VS_WRITE, VS_TURN:
				if (adv)
				begin
					if (req == VEC_ADDR)
						nxt = VS_ADDR;
					else if (req == VEC_WRITE)
						nxt = VS_WRITE;
					else if (req == VEC_READ)
						nxt = VS_READ;
					else
						nxt = VS_IDLE;
				end
			VS_READ:
				if (adv)
					nxt = (req == VEC_READ) ? VS_READ : VS_LAST;
			VS_LAST:
				if (adv)
					nxt = VS_TURN;
			default:
				nxt = VS_IDLE;
		endcase
		// Exit reaches idle from any state except read.
		if (!q.req_a_s2 && q.vst != VS_IDLE && !vector_request_b_i && q.vst != VS_READ)
			nxt = VS_IDLE;
		n.vst = nxt;

		latch_now = (q.vst == VS_ADDR) && adv && !(q.prev_was_addr && req != VEC_ADDR);
		if (q.vst == VS_ADDR && adv)
		begin
			if (q.prev_was_addr && req != VEC_ADDR)
			begin
				if (shared_vector_bus_i[CV_VALID])
				begin
					n.size = {shared_vector_bus_i[CV_SIZE1], shared_vector_bus_i[CV_SIZE0]};
					n.lock = shared_vector_bus_i[CV_LOCK];
					n.inc_en = shared_vector_bus_i[CV_INC_EN];
					n.prot = {shared_vector_bus_i[CV_PROT3], shared_vector_bus_i[CV_PROT2],
						shared_vector_bus_i[CV_PROT1], shared_vector_bus_i[CV_PROT0]};
				end
			end
			else
			begin
				n.held_addr = shared_vector_bus_i;
				n.first_xfer = 1'b1;
			end
		end
		if (adv)
			n.prev_was_addr = (q.vst == VS_ADDR);

		// Write data sampled in write state.
		if (q.vst == VS_WRITE && adv)
			n.hwdata = shared_vector_bus_i;

		is_wr = (nxt == VS_WRITE);
		issue = adv && (nxt == VS_WRITE || nxt == VS_READ);
		base_addr = latch_now ? shared_vector_bus_i : q.held_addr;
		base_first = latch_now || q.first_xfer;
		{wrap, xfer_addr} = inc_addr(base_addr, q.size);
		if (base_first || !q.inc_en)
		begin
			xfer_addr = base_addr;
			wrap = 1'b0;
		end
		seq_ok = q.inc_en && !base_first && q.htrans != HT_IDLE &&
			q.gst == GS_OWNED && !(is_wr && !q.last_wr);

		rsp_fail = q.dphase_act && !hready_i && (hresp_i == HR_RETRY || hresp_i == HR_SPLIT);
		if (rsp_fail)
		begin
			n.regen = 1'b1;
			n.htrans = HT_IDLE;
			n.dphase_act = 1'b0;
		end
		else if (hready_i)
		begin
			n.dphase_act = (q.htrans != HT_IDLE);
			n.dphase_rd = (q.htrans != HT_IDLE) && !q.hwrite;
			n.htrans = HT_IDLE;
			n.hwrite = 1'b0;
			if (q.regen && hgrant_i)
			begin
				n.regen = 1'b0;
				n.htrans = HT_NONSEQ;
				n.haddr = q.prev_addr;
				n.held_addr = q.prev_addr;
				n.hwrite = q.last_wr;
			end
			else if (issue)
			begin
				n.htrans = (seq_ok && !wrap) ? HT_SEQ : HT_NONSEQ;
				n.haddr = xfer_addr;
				n.prev_addr = xfer_addr;
				n.held_addr = xfer_addr;
				n.first_xfer = 1'b0;
				n.hwrite = is_wr;
				n.last_wr = is_wr;
			end
		end

		n.first_rd = (nxt == VS_READ) && (q.vst != VS_READ || (q.first_rd && !adv));
		// Drive only in later reads and final read.
		n.oe = (nxt == VS_LAST) || (nxt == VS_READ && !n.first_rd);
		rd_pending = n.dphase_rd || (n.htrans != HT_IDLE && !n.hwrite);
		n.ack = (nxt != VS_IDLE) && hgrant_i && hready_i && buf_in_ready && !n.regen &&
			!(nxt == VS_LAST && rd_pending);
		n.busreq = (nxt != VS_IDLE);
		if (nxt == VS_IDLE)
		begin
			n.prev_was_addr = 1'b0;
			n.first_xfer = 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Read data path
	// ----------------------------------------------------------------
	assign buf_in_valid = q.dphase_rd && hready_i && hresp_i == HR_OKAY;
	assign buf_out_ready = q.oe && (adv || (q.vst == VS_LAST && (!buf_in_ready || buf_in_valid)));

	vector_read_buffer u_rd_buf (
		.core_clk_i  (core_clk_i),
		.nrst_i      (nrst_i),
		.in_valid_i  (buf_in_valid),
		.in_ready_o  (buf_in_ready),
		.in_data_i   (hrdata_i),
		.out_valid_o (),
		.out_ready_i (buf_out_ready),
		.out_data_o  (shared_vector_bus_o)
	);

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	// Rising edge, async low reset.
	always_ff @(posedge core_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			q <= '0;
			q.vst <= VS_IDLE;
			q.gst <= GS_OTHER;
			q.size <= SIZE_RST;
			q.prot <= PROT_RST;
			q.inc_en <= 1'b0;
			q.htrans <= HT_IDLE;
		end
		else
			q <= n;
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign shared_vector_bus_oe_o = q.oe;
	assign vector_acknowledge_o = q.ack;
	assign hbusreq_o = q.busreq;
	assign hlock_o = q.lock;
	assign htrans_o = q.htrans;
	assign haddr_o = q.haddr;
	assign hwrite_o = q.hwrite;
	assign hsize_o = {1'b0, q.size};
	assign hburst_o = HB_INCR;
	assign hprot_o = q.prot;
	assign hwdata_o = q.hwdata;

endmodule
`default_nettype wire

// file: core/vector_access_pkg.sv
// Constants and types shared by the vector access controller design files.
package vector_access_pkg;

	// ----------------------------------------------------------------
	// Widths
	// ----------------------------------------------------------------
	localparam int unsigned BUS_W = 32;
	localparam int unsigned INC_W = 8;

	// ----------------------------------------------------------------
	// Vector codes on {vector_request_a, vector_request_b}
	// ----------------------------------------------------------------
	localparam logic [1:0] VEC_EXIT  = 2'h0;
	localparam logic [1:0] VEC_READ  = 2'h1;
	localparam logic [1:0] VEC_WRITE = 2'h2;
	localparam logic [1:0] VEC_ADDR  = 2'h3;

	// ----------------------------------------------------------------
	// Control vector field positions
	// ----------------------------------------------------------------
	localparam int unsigned CV_VALID  = 0;
	localparam int unsigned CV_SIZE0  = 2;
	localparam int unsigned CV_SIZE1  = 3;
	localparam int unsigned CV_LOCK   = 4;
	localparam int unsigned CV_PROT0  = 5;
	localparam int unsigned CV_PROT1  = 6;
	localparam int unsigned CV_INC_EN = 7;
	localparam int unsigned CV_PROT2  = 9;
	localparam int unsigned CV_PROT3  = 10;

	// ----------------------------------------------------------------
	// System bus encodings and reset values
	// ----------------------------------------------------------------
	localparam logic [1:0] HT_IDLE   = 2'h0;
	localparam logic [1:0] HT_NONSEQ = 2'h2;
	localparam logic [1:0] HT_SEQ    = 2'h3;
	localparam logic [2:0] HB_INCR   = 3'h1;
	localparam logic [1:0] HR_OKAY   = 2'h0;
	localparam logic [1:0] HR_RETRY  = 2'h2;
	localparam logic [1:0] HR_SPLIT  = 2'h3;
	localparam logic [1:0] SZ_BYTE   = 2'h0;
	localparam logic [1:0] SZ_HALF   = 2'h1;
	localparam logic [1:0] SZ_WORD   = 2'h2;
	localparam logic [1:0] SIZE_RST  = SZ_WORD;
	localparam logic [3:0] PROT_RST  = 4'h3;

	// ----------------------------------------------------------------
	// State types
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		VS_IDLE  = 3'h0,
		VS_START = 3'h1,
		VS_ADDR  = 3'h3,
		VS_WRITE = 3'h2,
		VS_READ  = 3'h6,
		VS_LAST  = 3'h7,
		VS_TURN  = 3'h5
	} vec_state_t;

	typedef enum logic {
		GS_OTHER = 1'b0,
		GS_OWNED = 1'b1
	} grant_state_t;

endpackage

// file: core/vector_read_buffer.sv
// Two-entry read data buffer between the system bus and the vector bus.
`timescale 1ns/1ps
`default_nettype none
module vector_read_buffer
	import vector_access_pkg::*;
(
	// Clock and reset
	input  wire logic             core_clk_i,
	input  wire logic             nrst_i,
	// Filling side
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	input  wire logic [BUS_W-1:0] in_data_i,
	// Draining side
	output logic                  out_valid_o,
	input  wire logic             out_ready_i,
	output logic      [BUS_W-1:0] out_data_o
);

	typedef struct packed {
		logic             head_v;
		logic [BUS_W-1:0] head;
		logic             spare_v;
		logic [BUS_W-1:0] spare;
	} buf_t;

	buf_t q;
	buf_t d;
	logic pop;
	logic push;

	// ----------------------------------------------------------------
	// Next entry contents
	// ----------------------------------------------------------------
	always_comb
	begin
		d = q;
		pop = out_ready_i & q.head_v;
		push = in_valid_i & ~q.spare_v;
		if (pop)
		begin
			if (q.spare_v)
			begin
				d.head = q.spare;
				d.spare_v = 1'b0;
			end
			else
			begin
				d.head_v = push;
				if (push)
					d.head = in_data_i;
			end
		end
		else if (push)
		begin
			if (!q.head_v)
			begin
				d.head_v = 1'b1;
				d.head = in_data_i;
			end
			else
			begin
				d.spare_v = 1'b1;
				d.spare = in_data_i;
			end
		end
	end

	always_ff @(posedge core_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			q <= '0;
		else
			q <= d;
	end

	assign in_ready_o = ~q.spare_v;
	assign out_valid_o = q.head_v;
	assign out_data_o = q.head;

endmodule
`default_nettype wire

// file: tb/tb_top.sv
// Self-checking testbench for the vector access controller.
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import vector_access_pkg::*;
;
	logic             clk;
	logic             nrst = 1'b0;
	logic             hready = 1'b1;
	logic             stall = 1'b0;
	logic             req_a, req_b, ack, oe, busreq, hwrite, hlock;
	logic [BUS_W-1:0] bus_in, bus_out, hrdata, haddr, hwdata;
	logic [1:0]       htrans, dtr_q;
	logic [2:0]       hsize, hburst;
	logic [3:0]       hprot;
	logic             dph_q = 1'b0;
	logic             dwr_q = 1'b0;
	logic [BUS_W-1:0] dad_q = 32'h0;
	logic [BUS_W-1:0] wa[$], wd[$], rd[$];
	logic [1:0]       wt[$];
	logic [3:0]       cyc = 4'h0;
	int               n_errors = 0;
	int               checks = 0;
	vector_access_controller dut (.core_clk_i(clk), .nrst_i(nrst),
		.vector_request_a_i(req_a), .vector_request_b_i(req_b),
		.shared_vector_bus_i(bus_in), .shared_vector_bus_o(bus_out),
		.shared_vector_bus_oe_o(oe), .vector_acknowledge_o(ack),
		.clock_switch_done_i(1'b1), .hgrant_i(1'b1), .hready_i(hready),
		.hresp_i(HR_OKAY), .hrdata_i(hrdata), .hbusreq_o(busreq), .hlock_o(hlock),
		.htrans_o(htrans), .haddr_o(haddr), .hwrite_o(hwrite), .hsize_o(hsize),
		.hburst_o(hburst), .hprot_o(hprot), .hwdata_o(hwdata));
	vector_tester u_tst (.core_clk_i(clk), .ack_i(ack), .ready_i(hready), .oe_i(oe),
		.dev_bus_i(bus_out), .req_a_o(req_a), .req_b_o(req_b), .bus_o(bus_in));
	// ----
	// Clock, slave and monitor
	// ----
	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	assign hrdata = ~dad_q;
	always @(posedge clk)
	begin
		cyc <= cyc + 4'h1;
		hready <= !stall || cyc[1:0] != 2'h0;
		if (dph_q && dwr_q && hready)
		begin
			wa.push_back(dad_q);
			wd.push_back(hwdata);
			wt.push_back(dtr_q);
		end
		if (hready)
		begin
			dph_q <= htrans != HT_IDLE;
			dwr_q <= hwrite;
			dtr_q <= htrans;
			dad_q <= haddr;
		end
		if (oe && bus_out !== ((rd.size() == 0) ? 32'h0 : rd[$]))
			rd.push_back(bus_out);
	end
	// ----
	// Tasks
	// ----
	task automatic cmp(input string nm, input logic [BUS_W-1:0] e, input logic [BUS_W-1:0] g);
		checks++;
		if (g !== e)
		begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic close_out;
		$display("checks %0d mismatches %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic t_reset;
		#1;
		cmp("ack", 32'h0, 32'(ack));
		cmp("busreq", 32'h0, 32'(busreq));
		cmp("hsize", 32'h2, 32'(hsize));
		cmp("hprot", 32'h3, 32'(hprot));
		cmp("htrans", 32'(HT_IDLE), 32'(htrans));
		@(posedge clk);
		$display("t_reset done");
	endtask
	task automatic t_fixed;
		u_tst.step(VEC_ADDR, 1'b1, 32'h0);
		u_tst.step(VEC_WRITE, 1'b1, 32'h2000_0010);
		u_tst.step(VEC_WRITE, 1'b1, 32'ha5a5_0000);
		u_tst.step(VEC_ADDR, 1'b1, 32'ha5a5_0001);
		repeat (4) @(posedge clk);
		for (int i = 0; i < 2; i++)
		begin
			cmp("fix addr", 32'h2000_0010, wa[i]);
			cmp("fix trans", 32'(HT_NONSEQ), 32'(wt[i]));
			cmp("fix data", 32'ha5a5_0000 + 32'(i), wd[i]);
		end
		wa.delete();
		wd.delete();
		wt.delete();
		$display("t_fixed done");
	endtask
	task automatic t_write;
		logic [BUS_W-1:0] ea [3];
		logic [1:0]       et [3];
		ea = '{32'h1000_03f8, 32'h1000_03fc, 32'h1000_0000};
		et = '{HT_NONSEQ, HT_SEQ, HT_NONSEQ};
		u_tst.step(VEC_ADDR, 1'b1, 32'h1000_03f8);
		u_tst.step(VEC_WRITE, 1'b1, 32'h0000_04c9);
		u_tst.step(VEC_WRITE, 1'b1, 32'ha5a5_0000);
		u_tst.step(VEC_WRITE, 1'b1, 32'ha5a5_0001);
		u_tst.step(VEC_ADDR, 1'b1, 32'ha5a5_0002);
		repeat (4) @(posedge clk);
		cmp("wcount", 32'h3, 32'(wa.size()));
		for (int i = 0; i < 3; i++)
		begin
			cmp("waddr", ea[i], wa[i]);
			cmp("wtrans", 32'(et[i]), 32'(wt[i]));
			cmp("wdata", 32'ha5a5_0000 + 32'(i), wd[i]);
		end
		cmp("hprot", 32'ha, 32'(hprot));
		cmp("hlock", 32'h0, 32'(hlock));
		wa.delete();
		wd.delete();
		wt.delete();
		$display("t_write done");
	endtask
	task automatic t_read;
		rd.delete();
		stall <= 1'b1;
		u_tst.step(VEC_ADDR, 1'b1, 32'h3000_0100);
		u_tst.step(VEC_READ, 1'b1, 32'h0000_0004);
		u_tst.step(VEC_READ, 1'b0, 32'h0);
		u_tst.step(VEC_READ, 1'b0, 32'h0);
		u_tst.step(VEC_ADDR, 1'b0, 32'h0);
		u_tst.step(VEC_ADDR, 1'b0, 32'h0);
		u_tst.step(VEC_ADDR, 1'b0, 32'h0);
		repeat (4) @(posedge clk);
		stall <= 1'b0;
		cmp("rcount", 32'h3, 32'(rd.size()));
		for (int i = 0; i < 3; i++)
			cmp("rdata", ~(32'h3000_0100 + 32'(4 * i)), rd[i]);
		cmp("hsize", 32'h2, 32'(hsize));
		$display("t_read done");
	endtask
	task automatic t_exit;
		int n;
		u_tst.step(VEC_EXIT, 1'b1, 32'h0000_0040);
		n = 0;
		while (ack !== 1'b0 && n < 20)
		begin
			@(posedge clk);
			n++;
		end
		#1;
		cmp("ack", 32'h0, 32'(ack));
		cmp("busreq", 32'h0, 32'(busreq));
		cmp("wcount", 32'h0, 32'(wa.size()));
		$display("t_exit done");
	endtask
	// ----
	// Sequence and watchdog
	// ----
	initial
	begin
		repeat (6) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		t_reset();
		t_fixed();
		t_write();
		t_read();
		t_exit();
		cmp("stuck", 32'h0, 32'(u_tst.stuck));
		close_out();
	end
	initial
	begin
		#20000;
		n_errors++;
		close_out();
	end
endmodule
`default_nettype wire

// file: tb/vector_access_checker.sv
// Port assertions for the vector access controller.
`timescale 1ns/1ps
`default_nettype none
module vector_access_checker
	import vector_access_pkg::*;
(
	// Clock and reset
	input wire logic             core_clk_i,
	input wire logic             nrst_i,
	// Tester side
	input wire logic             vector_request_a_i,
	input wire logic             vector_request_b_i,
	input wire logic             shared_vector_bus_oe_o,
	input wire logic             vector_acknowledge_o,
	// System bus
	input wire logic             hgrant_i,
	input wire logic             hready_i,
	input wire logic             hbusreq_o,
	input wire logic [1:0]       htrans_o,
	input wire logic [BUS_W-1:0] haddr_o,
	input wire logic [2:0]       hsize_o,
	input wire logic [2:0]       hburst_o
);
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!nrst_i);
	// ----
	// Sequences
	// ----
	sequence s_turn;
		!shared_vector_bus_oe_o && htrans_o == HT_IDLE;
	endsequence
	sequence s_exit_req;
		(!vector_request_a_i && !vector_request_b_i && hready_i && hgrant_i)[*8];
	endsequence
	// ----
	// Assertions
	// ----
	// Burst kind.
	burst_incr_a: assert property (hburst_o == HB_INCR)
	else $error("burst type not incrementing");
	size_top_a: assert property (hsize_o[2] == 1'b0)
	else $error("size bit two set");
	reset_quiet_a: assert property ($rose(nrst_i) |-> !hbusreq_o && !vector_acknowledge_o)
	else $error("request or acknowledge after reset");
	idle_ack_a: assert property (!hbusreq_o |-> !vector_acknowledge_o)
	else $error("acknowledge high while idle");
	wait_hold_a: assert property (htrans_o != HT_IDLE && !hready_i |=> $stable(haddr_o) && $stable(htrans_o))
	else $error("transfer changed in wait state");
	seq_step_a: assert property ($past(hready_i) && $past(htrans_o) != HT_IDLE && htrans_o == HT_SEQ
		|-> haddr_o == $past(haddr_o) + (32'h1 << $past(hsize_o)))
	else $error("sequential address step wrong");
	turn_idle_a: assert property ($fell(shared_vector_bus_oe_o) |-> s_turn ##1 !shared_vector_bus_oe_o)
	else $error("turnaround cycle wrong");
	exit_ack_a: assert property (s_exit_req |-> !vector_acknowledge_o)
	else $error("acknowledge stays after exit");
endmodule
bind vector_access_controller vector_access_checker u_chk (.core_clk_i, .nrst_i,
	.vector_request_a_i, .vector_request_b_i, .shared_vector_bus_oe_o, .vector_acknowledge_o,
	.hgrant_i, .hready_i, .hbusreq_o, .htrans_o, .haddr_o, .hsize_o, .hburst_o);
`default_nettype wire

// file: tb/vector_tester.sv
// Model of the external tester applying vectors on the shared bus.
`timescale 1ns/1ps
`default_nettype none
module vector_tester
	import vector_access_pkg::*;
(
	// Clock
	input  wire logic             core_clk_i,
	// Device answers
	input  wire logic             ack_i,
	input  wire logic             ready_i,
	input  wire logic             oe_i,
	input  wire logic [BUS_W-1:0] dev_bus_i,
	// Vector side
	output logic                  req_a_o,
	output logic                  req_b_o,
	output logic      [BUS_W-1:0] bus_o
);
	logic             drv_q;
	logic [BUS_W-1:0] dat_q;
	logic [BUS_W-1:0] last_q;
	logic             stuck;
	initial
	begin
		req_a_o = 1'b0;
		req_b_o = 1'b0;
		drv_q = 1'b1;
		dat_q = 32'h0;
		last_q = 32'h0;
		stuck = 1'b0;
	end
	assign bus_o = oe_i ? dev_bus_i : (drv_q ? dat_q : ~last_q);
	always @(posedge core_clk_i) last_q <= bus_o;
	task automatic step(input logic [1:0] nxt, input logic drv, input logic [BUS_W-1:0] d);
		int   n;
		logic ok;
		req_a_o <= nxt[1];
		req_b_o <= nxt[0];
		drv_q <= drv;
		dat_q <= d;
		n = 0;
		do
		begin
			@(negedge core_clk_i);
			ok = ack_i && ready_i;
			@(posedge core_clk_i);
			n++;
		end
		while (!ok && n < 40);
		if (!ok)
			stuck = 1'b1;
	endtask
endmodule
`default_nettype wire
